// ---- core/sar_axil_slave.sv ----
// AXI4-Lite slave front end for the sequencer registers
`timescale 1ns/10ps
`include "sar_params.svh"
module sar_axil_slave #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  reg_access_if.slave regs
);
  logic aw_full_r;
  logic w_full_r;
  logic bvalid_r;
  logic rvalid_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [31:0] rdata_r;
  logic [1:0] bresp_r;
  logic [1:0] rresp_r;
  logic do_write;
  logic do_read;

  // Address and data are taken in either order; the write fires once both are held
  assign do_write = aw_full_r & w_full_r & ~bvalid_r;
  assign do_read = arvalid & ~rvalid_r;
  assign awready = ~aw_full_r;
  assign wready = ~w_full_r;
  assign arready = ~rvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign regs.wr_en = do_write;
  assign regs.wr_addr = aw_addr_r;
  assign regs.wdata = wdata_r;
  assign regs.wstrb = wstrb_r;
  assign regs.rd_addr = araddr;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (awvalid && !aw_full_r) begin
      aw_full_r <= 1'b1;
      aw_addr_r <= awaddr;
    end else if (do_write) begin
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      w_full_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (wvalid && !w_full_r) begin
      w_full_r <= 1'b1;
      wdata_r <= wdata;
      wstrb_r <= wstrb;
    end else if (do_write) begin
      w_full_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= regs.wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `RESP_OKAY;
    end else if (do_read) begin
      rvalid_r <= 1'b1;
      rdata_r <= regs.rd_hit ? regs.rd_data : '0;
      rresp_r <= regs.rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end
endmodule // sar_axil_slave

// ---- core/sar_bit_search.sv ----
// Successive-approximation search register, one decision per clock
`timescale 1ns/10ps
`include "sar_params.svh"
module sar_bit_search #(
  parameter int W = `RES_BITS
) (
  input wire logic clk,
  sar_search_if.engine srch
);
  logic active_r;
  logic [W-1:0] code_r;
  logic [W-1:0] bit_r;
  logic [W-1:0] kept;
  // Cycles into the search, so the bit count is checked without a long repetition
  logic [4:0] step_r;

  assign kept = srch.decide ? bit_r : '0;
  assign srch.trial = code_r | bit_r; // RULE3
  assign srch.code = code_r | kept;
  assign srch.last = active_r & bit_r[0];
  assign srch.active = active_r;

  always_ff @(posedge clk) begin
    if (srch.abort) begin
      active_r <= 1'b0;
      code_r <= '0;
      bit_r <= '0;
    end else if (srch.start) begin
      active_r <= 1'b1;
      code_r <= '0;
      bit_r <= {1'b1, {(W-1){1'b0}}}; // RULE4
    end else if (active_r) begin
      code_r <= code_r | kept; // RULE4
      bit_r <= bit_r >> 1;
      active_r <= ~bit_r[0];
    end
  end

  always_ff @(posedge clk) begin
    if (!active_r) begin
      step_r <= 5'h00;
    end else begin
      step_r <= step_r + 5'h01;
    end
  end

  msb_first_a: assert property ( // RULE4
    @(posedge clk) disable iff (srch.abort)
    $rose(active_r) |-> srch.trial == {1'b1, {(W-1){1'b0}}} ##1 srch.trial[W-2])
    else $error("search did not begin at the top bit");

  bit_count_a: assert property ( // RULE3
    @(posedge clk) disable iff (srch.abort)
    $rose(active_r) |-> ##15 srch.last ##1 !active_r)
    else $error("search did not take one cycle per bit");

  last_step_a: assert property ( // RULE3
    @(posedge clk) disable iff (srch.abort)
    srch.last |-> step_r == 5'(W - 1))
    else $error("last decision came at the wrong bit");
endmodule // sar_bit_search

// ---- core/sar_conversion_sequencer.sv ----
// Conversion sequencer of a 16-bit charge-redistribution SAR converter
//
// Contract
// RULE1 - Falling conversion start ends acquisition and begins conversion.
// RULE2 - Conversion opens ground switches first, then moves arrays to reference ground.
// RULE3 - Search runs over 16 binary weighted elements, one decision per bit.
// RULE4 - Bits resolve from the top down, kept or cleared by the comparator.
// RULE5 - At search end the final code is presented, then busy drops.
// RULE6 - Result belongs to the sample just converted, valid as busy falls.
// RULE7 - Fastest mode supports conversion rates up to 570 kSPS.
// RULE8 - Host keeps fastest-mode conversions no more than 1 ms apart.
// RULE9 - Host discards the first fastest-mode result after a gap over 1 ms.
// RULE10 - Both mode bits low selects normal mode, 500 kSPS, no gap limit.
// RULE11 - Low-power mode cuts power between conversions.
// RULE12 - Coding select chooses straight binary or two's complement.
// RULE13 - Two's complement equals straight binary with the top bit inverted.
// RULE14 - Over-range input gives FFFF binary, 7FFF two's complement.
// RULE15 - Under-range input gives 0000 binary, 8000 two's complement.
// RULE16 - Low-power mode restarts at once if start is still low after acquisition.
// RULE17 - Reset high resets the block and aborts any conversion.
// RULE18 - Power-down lets the current conversion finish, then inhibits conversions.
// RULE19 - Busy rises at conversion start and stays high until the result is complete.
// RULE20 - A running conversion ignores start edges until busy has fallen.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "sar_params.svh"
module sar_conversion_sequencer
  import sar_pkg::*;
#(
  parameter int RES_BITS = `RES_BITS,
  parameter int ADDR_W = 8,
  parameter int GAP_CYCLES = `WARP_GAP_CYCLES
) (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic CONVERSION_START_N,
  input wire logic COMPARATOR_IN,
  input wire logic OVER_RANGE,
  input wire logic UNDER_RANGE,
  output logic SAMPLE_SWITCH_CLOSED,
  output logic ARRAY_GROUND_SWITCH,
  output logic REFERENCE_CAP_GROUND_SWITCH,
  output logic REFERENCE_GROUND_SELECT,
  output logic [RES_BITS-1:0] CAP_SWITCHES,
  output logic BUSY,
  output logic [RES_BITS-1:0] RESULT_CODE,
  output logic POWER_SAVE
);
  localparam int GW = $clog2(GAP_CYCLES + 1);

  sar_search_if #(.W(RES_BITS)) srch();
  reg_access_if #(.ADDR_W(ADDR_W)) regs();

  seq_state_t state_r;
  seq_state_t state_nxt;
  conv_mode_t mode;
  logic [4:0] ctrl_r;
  logic [4:0] ctrl_nxt;
  logic [3:0] acq_cnt_r;
  logic [3:0] acq_cnt_nxt;
  logic [3:0] acq_need;
  logic [GW-1:0] gap_cnt_r;
  logic [RES_BITS-1:0] result_r;
  logic [RES_BITS-1:0] result_nxt;
  logic [RES_BITS-1:0] raw_code;
  logic [RES_BITS-1:0] final_code;
  logic start_prev_r;
  logic busy_r;
  logic busy_nxt;
  logic over_q_r;
  logic under_q_r;
  logic stale_r;
  logic power_save_r;
  logic power_save_nxt;
  logic low_power;
  logic fast;
  logic coding_binary;
  logic power_down;
  logic soft_reset;
  logic abort;
  logic falling;
  logic accept;
  logic auto_restart;
  logic go;
  logic done;
  logic gap_full;
  logic wr_ctrl;
  logic rd_ctrl;
  logic rd_status;
  logic rd_result;
  logic [31:0] status_word;

  sar_axil_slave #(.ADDR_W(ADDR_W)) bus (
    .clk(MCLK),
    .rst_n(RESETN),
    .awaddr(AWADDR),
    .awvalid(AWVALID),
    .awready(AWREADY),
    .wdata(WDATA),
    .wstrb(WSTRB),
    .wvalid(WVALID),
    .wready(WREADY),
    .bresp(BRESP),
    .bvalid(BVALID),
    .bready(BREADY),
    .araddr(ARADDR),
    .arvalid(ARVALID),
    .arready(ARREADY),
    .rdata(RDATA),
    .rresp(RRESP),
    .rvalid(RVALID),
    .rready(RREADY),
    .regs(regs.slave)
  );

  sar_bit_search #(.W(RES_BITS)) search (
    .clk(MCLK),
    .srch(srch.engine)
  );

  // Control fields
  assign low_power = ctrl_r[`CTRL_LOW_POWER_BIT];
  assign fast = ctrl_r[`CTRL_FAST_BIT];
  assign coding_binary = ctrl_r[`CTRL_CODING_BIT];
  assign power_down = ctrl_r[`CTRL_POWER_DOWN_BIT];
  assign soft_reset = ctrl_r[`CTRL_RESET_BIT];
  // Reset bit is a level: the sequencer stays cleared while it is set
  assign abort = ~RESETN | soft_reset; // RULE17

  // Fast bit wins over low power, as with the mode pins
  assign mode = fast ? MODE_WARP : (low_power ? MODE_IMPULSE : MODE_NORMAL); // RULE10
  // Acquisition pads each mode to its rated period (17, 20, 22 cycles)
  assign acq_need = (mode == MODE_WARP) ? 4'(`WARP_ACQ_CYCLES) : // RULE7
                    (mode == MODE_IMPULSE) ? 4'(`IMPULSE_ACQ_CYCLES) :
                    4'(`NORMAL_ACQ_CYCLES); // RULE10

  // Start edges count only while idle and not powered down
  assign falling = start_prev_r & ~CONVERSION_START_N;
  assign accept = (state_r == ST_IDLE) & falling & ~power_down; // RULE1 RULE18 RULE20
  assign auto_restart = (state_r == ST_ACQ) & (acq_cnt_r == 4'h1) & (mode == MODE_IMPULSE) &
                        ~CONVERSION_START_N & ~power_down; // RULE16
  assign go = accept | auto_restart;
  assign done = (state_r == ST_SEARCH) & srch.last;

  // Clamp and coding of the final code
  assign raw_code = over_q_r ? `CODE_FULL_BINARY : // RULE14
                    under_q_r ? `CODE_ZERO_BINARY : srch.code; // RULE15
  assign final_code = coding_binary ? raw_code : (raw_code ^ `CODE_MSB_MASK); // RULE12 RULE13

  // Search handshake
  assign srch.start = (state_r == ST_HOLD);
  assign srch.abort = abort;
  assign srch.decide = COMPARATOR_IN; // RULE4

  // Switch drive decoded from the state register
  assign SAMPLE_SWITCH_CLOSED = (state_r != ST_SEARCH);
  assign ARRAY_GROUND_SWITCH = (state_r == ST_IDLE) | (state_r == ST_ACQ); // RULE2
  assign REFERENCE_CAP_GROUND_SWITCH = ARRAY_GROUND_SWITCH; // RULE2
  assign REFERENCE_GROUND_SELECT = (state_r == ST_SEARCH); // RULE2
  assign CAP_SWITCHES = REFERENCE_GROUND_SELECT ? srch.trial : '0; // RULE3
  assign BUSY = busy_r;
  assign RESULT_CODE = result_r;
  assign POWER_SAVE = power_save_r;

  // Register decode
  assign regs.wr_hit = (regs.wr_addr == `CTRL_OFFSET);
  assign wr_ctrl = regs.wr_en & regs.wr_hit & regs.wstrb[0];
  assign rd_ctrl = (regs.rd_addr == `CTRL_OFFSET);
  assign rd_status = (regs.rd_addr == `STATUS_OFFSET);
  assign rd_result = (regs.rd_addr == `RESULT_OFFSET);
  assign regs.rd_hit = rd_ctrl | rd_status | rd_result;
  assign status_word = {29'h0000_0000, stale_r, power_save_r, busy_r};
  assign regs.rd_data = rd_ctrl ? {27'h000_0000, ctrl_r} :
                        rd_status ? status_word :
                        rd_result ? {16'h0000, result_r} : 32'h0000_0000;
  assign ctrl_nxt = wr_ctrl ? regs.wdata[4:0] : ctrl_r;

  // Sequencer state
  always_comb begin
    state_nxt = state_r;
    acq_cnt_nxt = acq_cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (go) begin
          state_nxt = ST_HOLD; // RULE1
        end
      end
      ST_HOLD: begin
        state_nxt = ST_SEARCH;
      end
      ST_SEARCH: begin
        if (done) begin
          state_nxt = (acq_need == 4'h0) ? ST_IDLE : ST_ACQ;
          acq_cnt_nxt = acq_need;
        end
      end
      ST_ACQ: begin
        acq_cnt_nxt = acq_cnt_r - 4'h1;
        if (acq_cnt_r == 4'h1) begin
          state_nxt = go ? ST_HOLD : ST_IDLE; // RULE16
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Busy from hold to the last decision; result written on the same edge
  assign busy_nxt = go ? 1'b1 : (done ? 1'b0 : busy_r); // RULE19
  assign result_nxt = done ? final_code : result_r; // RULE5 RULE6
  // Power is cut whenever not busy, in low-power mode or when powered down
  assign power_save_nxt = ~busy_nxt & (power_down | (mode == MODE_IMPULSE)); // RULE11 RULE18
  assign gap_full = (gap_cnt_r == GW'(GAP_CYCLES));

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      ctrl_r <= `CTRL_RESET_VALUE;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge MCLK) begin
    if (abort) begin
      state_r <= ST_IDLE; // RULE17
      acq_cnt_r <= 4'h0;
      busy_r <= 1'b0;
      power_save_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      acq_cnt_r <= acq_cnt_nxt;
      busy_r <= busy_nxt;
      power_save_r <= power_save_nxt;
    end
  end

  always_ff @(posedge MCLK) begin
    if (abort) begin
      result_r <= '0;
      start_prev_r <= 1'b1;
    end else begin
      result_r <= result_nxt;
      start_prev_r <= CONVERSION_START_N;
    end
  end

  // Range flags are caught at the hold instant, with the sample
  always_ff @(posedge MCLK) begin
    if (abort) begin
      over_q_r <= 1'b0;
      under_q_r <= 1'b0;
    end else if (go) begin
      over_q_r <= OVER_RANGE;
      under_q_r <= UNDER_RANGE & ~OVER_RANGE;
    end
  end

  // Gap between starts; starts saturated so the first warp result is marked stale
  always_ff @(posedge MCLK) begin
    if (abort) begin
      gap_cnt_r <= GW'(GAP_CYCLES);
      stale_r <= 1'b0;
    end else if (go) begin
      gap_cnt_r <= '0;
      stale_r <= (mode == MODE_WARP) & gap_full; // RULE9
    end else if (!gap_full) begin
      gap_cnt_r <= gap_cnt_r + GW'(1);
    end
  end

  // Checks
  logic [4:0] busy_len_r;

  always_ff @(posedge MCLK) begin
    if (abort || !busy_r) begin
      busy_len_r <= 5'h01;
    end else begin
      busy_len_r <= busy_len_r + 5'h01;
    end
  end

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (abort);

  start_hold_a: assert property ( // RULE1
    state_r == ST_IDLE && falling && !power_down |=> BUSY && state_r == ST_HOLD)
    else $error("falling start did not begin a conversion");

  switch_order_a: assert property ( // RULE2
    $rose(BUSY) |-> !ARRAY_GROUND_SWITCH && !REFERENCE_CAP_GROUND_SWITCH &&
      SAMPLE_SWITCH_CLOSED ##1 REFERENCE_GROUND_SELECT && !SAMPLE_SWITCH_CLOSED)
    else $error("switches did not open before moving to reference ground");

  busy_length_a: assert property ( // RULE19
    $fell(BUSY) |-> $past(busy_len_r) == 5'd17)
    else $error("busy did not span hold plus sixteen decisions");

  result_fresh_a: assert property ( // RULE6
    $past(done) |-> !BUSY && RESULT_CODE == $past(final_code))
    else $error("result not taken from the conversion that just ended");

  twos_code_a: assert property ( // RULE13
    $fell(BUSY) && !$past(over_q_r) && !$past(under_q_r) |->
      RESULT_CODE == ($past(srch.code) ^ ($past(coding_binary) ? 16'h0000 : 16'h8000)))
    else $error("coding of the result is wrong");

  over_clamp_a: assert property ( // RULE14
    $fell(BUSY) && $past(over_q_r) |->
      RESULT_CODE == ($past(coding_binary) ? 16'hFFFF : 16'h7FFF))
    else $error("over-range did not give full-scale code");

  under_clamp_a: assert property ( // RULE15
    $fell(BUSY) && $past(under_q_r) && !$past(over_q_r) |->
      RESULT_CODE == ($past(coding_binary) ? 16'h0000 : 16'h8000))
    else $error("under-range did not give zero-scale code");

  edge_ignored_a: assert property ( // RULE20
    state_r == ST_SEARCH && !srch.last |=> BUSY && state_r != ST_HOLD)
    else $error("conversion disturbed before busy fell");

  power_down_a: assert property ( // RULE18
    power_down && !BUSY && !$past(go) |=> !BUSY [*2])
    else $error("conversion started while powered down");

  impulse_restart_a: assert property ( // RULE16
    auto_restart |=> state_r == ST_HOLD ##17 !BUSY)
    else $error("held start did not restart in low-power mode");

  warp_rate_a: assert property ( // RULE7
    $fell(BUSY) && $past(mode) == MODE_WARP |-> state_r == ST_IDLE)
    else $error("warp mode not ready for a start right after busy fell");

  reset_abort_a: assert property ( // RULE17
    @(posedge MCLK) disable iff (!RESETN)
    soft_reset && BUSY |=> !BUSY && state_r == ST_IDLE && RESULT_CODE == 16'h0000)
    else $error("reset did not abort the conversion");
endmodule // sar_conversion_sequencer

// ---- core/sar_links_if.sv ----
// Interfaces between the sequencer, its search register and its bus slave
`timescale 1ns/10ps
`include "sar_params.svh"

interface sar_search_if #(parameter int W = `RES_BITS);
  logic start;
  logic abort;
  logic decide;
  logic active;
  logic last;
  logic [W-1:0] trial;
  logic [W-1:0] code;
  modport ctrl(output start, abort, decide, input active, last, trial, code);
  modport engine(input start, abort, decide, output active, last, trial, code);
endinterface

interface reg_access_if #(parameter int ADDR_W = 8);
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wr_hit;
  logic [ADDR_W-1:0] rd_addr;
  logic rd_hit;
  logic [31:0] rd_data;
  modport slave(output wr_en, wr_addr, wdata, wstrb, rd_addr, input wr_hit, rd_hit, rd_data);
  modport regs(input wr_en, wr_addr, wdata, wstrb, rd_addr, output wr_hit, rd_hit, rd_data);
endinterface

// ---- core/sar_params.svh ----
// Offsets, field positions, reset values and timing counts of the SAR sequencer
`ifndef SAR_PARAMS_SVH
`define SAR_PARAMS_SVH

`define RES_BITS 16
`define CLK_PERIOD_NS 100
`define CONV_CYCLES 17

`define WARP_MIN_PERIOD_NS 1754
`define NORMAL_MIN_PERIOD_NS 2000
`define IMPULSE_MIN_PERIOD_NS 2252
`define WARP_ACQ_CYCLES (`WARP_MIN_PERIOD_NS / `CLK_PERIOD_NS - `CONV_CYCLES)
`define NORMAL_ACQ_CYCLES (`NORMAL_MIN_PERIOD_NS / `CLK_PERIOD_NS - `CONV_CYCLES)
`define IMPULSE_ACQ_CYCLES (`IMPULSE_MIN_PERIOD_NS / `CLK_PERIOD_NS - `CONV_CYCLES)
`define WARP_GAP_TIME_NS 1000000
`define WARP_GAP_CYCLES (`WARP_GAP_TIME_NS / `CLK_PERIOD_NS)

`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define RESULT_OFFSET 8'h08
`define CTRL_RESET_VALUE 5'h04
`define CTRL_LOW_POWER_BIT 0
`define CTRL_FAST_BIT 1
`define CTRL_CODING_BIT 2
`define CTRL_POWER_DOWN_BIT 3
`define CTRL_RESET_BIT 4

`define CODE_FULL_BINARY 16'hFFFF
`define CODE_FULL_TWOS 16'h7FFF
`define CODE_ZERO_BINARY 16'h0000
`define CODE_ZERO_TWOS 16'h8000
`define CODE_MSB_MASK 16'h8000

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- core/sar_pkg.sv ----
// Types shared by the SAR sequencer modules
package sar_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_SEARCH, ST_ACQ} seq_state_t;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_IMPULSE, MODE_WARP} conv_mode_t;
endpackage

// ---- tb/analog_front.sv ----
// Behavioural comparator standing for the sampled analog input
`timescale 1ns/10ps
module analog_front (
  input wire logic [15:0] cap_switches,
  input wire logic [15:0] level,
  output logic keep
);
  // Keep the trial bit while the trial code does not pass the held level
  assign keep = (cap_switches <= level);
endmodule // analog_front

// ---- tb/tb_top.sv ----
// Self-checking bench for the SAR conversion sequencer
`timescale 1ns/10ps
`include "sar_params.svh"
module tb_top;
  typedef struct {logic [31:0] ctrl; logic [15:0] lvl; logic ov; logic un; logic [15:0] code;} row_t;
  logic MCLK, RESETN, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY;
  logic RVALID, RREADY, CONVERSION_START_N, COMPARATOR_IN, OVER_RANGE, UNDER_RANGE;
  logic SAMPLE_SWITCH_CLOSED, ARRAY_GROUND_SWITCH, REFERENCE_CAP_GROUND_SWITCH;
  logic REFERENCE_GROUND_SELECT, BUSY, POWER_SAVE;
  logic [7:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP;
  logic [15:0] CAP_SWITCHES, RESULT_CODE, level;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  row_t rows [10] = '{
    '{32'h0000_0004, 16'h1234, 1'b0, 1'b0, 16'h1234}, '{32'h0000_0000, 16'h1234, 1'b0, 1'b0, 16'h9234},
    '{32'h0000_0000, 16'h8000, 1'b0, 1'b0, 16'h0000}, '{32'h0000_0006, 16'h0000, 1'b1, 1'b0, 16'hFFFF},
    '{32'h0000_0002, 16'h0000, 1'b1, 1'b0, 16'h7FFF}, '{32'h0000_0005, 16'hFFFF, 1'b0, 1'b1, 16'h0000},
    '{32'h0000_0001, 16'hFFFF, 1'b0, 1'b1, 16'h8000}, '{32'h0000_0004, 16'h0001, 1'b1, 1'b1, 16'hFFFF},
    '{32'h0000_0004, 16'hFFFF, 1'b0, 1'b0, 16'hFFFF}, '{32'h0000_0006, 16'h0000, 1'b0, 1'b0, 16'h0000}};

  sar_conversion_sequencer #(.GAP_CYCLES(40)) DUT (.MCLK, .RESETN, .AWADDR, .AWVALID, .AWREADY,
    .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY,
    .RDATA, .RRESP, .RVALID, .RREADY, .CONVERSION_START_N, .COMPARATOR_IN, .OVER_RANGE,
    .UNDER_RANGE, .SAMPLE_SWITCH_CLOSED, .ARRAY_GROUND_SWITCH, .REFERENCE_CAP_GROUND_SWITCH,
    .REFERENCE_GROUND_SELECT, .CAP_SWITCHES, .BUSY, .RESULT_CODE, .POWER_SAVE);
  analog_front front (.cap_switches(CAP_SWITCHES), .level(level), .keep(COMPARATOR_IN));

  always #50 MCLK = ~MCLK;
  // Cut a hang short well past the expected run length
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      summarize();
    end
  end

  task summarize;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Waits as long as the slave takes; only the cycle ceiling ends a hang
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge MCLK);
    AWADDR <= a; WDATA <= d; WSTRB <= 4'hF; AWVALID <= 1; WVALID <= 1; BREADY <= 1;
    forever begin
      @(posedge MCLK);
      if (AWREADY) AWVALID <= 0;
      if (WREADY) WVALID <= 0;
      if (BVALID) break;
    end
    BREADY <= 0;
    chk(BRESP, er, "write response");
  endtask

  task axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge MCLK);
    ARADDR <= a; ARVALID <= 1; RREADY <= 1;
    forever begin
      @(posedge MCLK);
      if (ARREADY) ARVALID <= 0;
      if (RVALID) break;
    end
    RREADY <= 0;
    chk(RDATA, ed, "read data");
    chk(RRESP, er, "read response");
  endtask

  // Returns just after the start edge unless asked to run to completion
  task conv(input logic [15:0] lvl, input logic ov, input logic un, input bit to_end);
    @(posedge MCLK);
    level <= lvl; OVER_RANGE <= ov; UNDER_RANGE <= un; CONVERSION_START_N <= 1;
    repeat (6) @(posedge MCLK);
    CONVERSION_START_N <= 0;
    @(posedge MCLK);
    CONVERSION_START_N <= 1;
    #1;
    chk({BUSY, SAMPLE_SWITCH_CLOSED, ARRAY_GROUND_SWITCH, REFERENCE_CAP_GROUND_SWITCH},
        4'b1100, "start");
    n = 1;
    if (to_end) begin
      @(posedge MCLK);
      #1;
      chk({SAMPLE_SWITCH_CLOSED, REFERENCE_GROUND_SELECT, CAP_SWITCHES}, {2'b01, 16'h8000},
          "first trial");
      n = 2;
      while (n < 40) begin
        @(posedge MCLK);
        #1;
        if (!BUSY) break;
        n++;
      end
      chk(n, 17, "busy length");
    end
  endtask

  initial begin
    MCLK = 0; RESETN = 0; AWVALID = 0; WVALID = 0; BREADY = 0; ARVALID = 0; RREADY = 0;
    AWADDR = 0; ARADDR = 0; WDATA = 0; WSTRB = 0; level = 0; OVER_RANGE = 0; UNDER_RANGE = 0;
    CONVERSION_START_N = 1;
    repeat (12) @(posedge MCLK);
    RESETN <= 1;
    axr(`CTRL_OFFSET, 32'h0000_0004, `RESP_OKAY);
    // Host keeps warp conversions close together in these rows
    foreach (rows[i]) begin
      axw(`CTRL_OFFSET, rows[i].ctrl, `RESP_OKAY);
      conv(rows[i].lvl, rows[i].ov, rows[i].un, 1);
      chk(RESULT_CODE, rows[i].code, "result");
      axr(`RESULT_OFFSET, {16'h0000, rows[i].code}, `RESP_OKAY);
      chk(POWER_SAVE, rows[i].ctrl[0] & ~rows[i].ctrl[1], "power save");
      $display("row %0d done", i);
    end
    axr(8'h10, 32'h0000_0000, `RESP_SLVERR);
    axw(`RESULT_OFFSET, 32'h0000_1111, `RESP_SLVERR);
    axr(`RESULT_OFFSET, 32'h0000_0000, `RESP_OKAY);
    $display("bus refusals done");
    // Warp start after a long quiet spell is flagged stale for the host to drop
    repeat (45) @(posedge MCLK);
    conv(16'h0123, 0, 0, 1);
    axr(`STATUS_OFFSET, 32'h0000_0004, `RESP_OKAY);
    conv(16'h0123, 0, 0, 1);
    chk(RESULT_CODE, 16'h0123, "warp result");
    axr(`STATUS_OFFSET, 32'h0000_0000, `RESP_OKAY);
    $display("stale flag done");
    // Start edge during busy must not stretch or restart
    axw(`CTRL_OFFSET, 32'h0000_0004, `RESP_OKAY);
    conv(16'h0F0F, 0, 0, 0);
    repeat (3) @(posedge MCLK);
    CONVERSION_START_N <= 0;
    repeat (2) @(posedge MCLK);
    CONVERSION_START_N <= 1;
    repeat (13) @(posedge MCLK);
    #1;
    chk({BUSY, RESULT_CODE}, {1'b0, 16'h0F0F}, "ignored restart");
    $display("start during busy done");
    // Power-down mid conversion lets it finish, then blocks starts
    conv(16'h00FF, 0, 0, 0);
    axw(`CTRL_OFFSET, 32'h0000_000C, `RESP_OKAY);
    repeat (16) @(posedge MCLK);
    #1;
    chk({BUSY, RESULT_CODE}, {1'b0, 16'h00FF}, "finish under power-down");
    @(posedge MCLK);
    CONVERSION_START_N <= 0;
    repeat (4) @(posedge MCLK);
    #1;
    chk({BUSY, POWER_SAVE}, 2'b01, "blocked start");
    @(posedge MCLK);
    CONVERSION_START_N <= 1;
    $display("power-down done");
    // Low-power mode with start held low keeps converting on its own
    axw(`CTRL_OFFSET, 32'h0000_0005, `RESP_OKAY);
    @(posedge MCLK);
    CONVERSION_START_N <= 0;
    n = 0;
    repeat (60) begin
      @(posedge MCLK);
      #1;
      if (BUSY && !SAMPLE_SWITCH_CLOSED && CAP_SWITCHES === 16'h8000) n++;
    end
    chk(n >= 2, 1, "auto restart");
    @(posedge MCLK);
    CONVERSION_START_N <= 1;
    $display("auto restart done");
    // Soft reset aborts a running conversion
    axw(`CTRL_OFFSET, 32'h0000_0004, `RESP_OKAY);
    conv(16'h0ABC, 0, 0, 0);
    axw(`CTRL_OFFSET, 32'h0000_0014, `RESP_OKAY);
    #1;
    chk({BUSY, RESULT_CODE}, 17'h0_0000, "soft reset");
    axw(`CTRL_OFFSET, 32'h0000_0004, `RESP_OKAY);
    // Hard reset aborts as well and restores the control word
    conv(16'h0ABC, 0, 0, 0);
    @(posedge MCLK);
    RESETN <= 0;
    repeat (2) @(posedge MCLK);
    RESETN <= 1;
    #1;
    chk({BUSY, RESULT_CODE, SAMPLE_SWITCH_CLOSED}, 18'h0_0001, "hard reset");
    axr(`CTRL_OFFSET, 32'h0000_0004, `RESP_OKAY);
    $display("reset tests done");
    summarize();
  end
endmodule // tb_top
